// ===== common/ephy_pkg.sv
/*
 Package for the PHY-side port: register map, field positions,
 reset values and timing counts. Assumes a 200 MHz core clock.
*/
package ephy_pkg;
   // -----------------------------------------------------------
   // Register map
   // -----------------------------------------------------------
   localparam logic [7:0] OFS_ADDR_CTRL = 8'h00;
   localparam logic [7:0] OFS_DATA      = 8'h04;
   localparam logic [7:0] OFS_CFG       = 8'h08;
   localparam logic [7:0] OFS_STATUS    = 8'h0C;
   localparam int BIT_BUSY   = 0;
   localparam int BIT_WRITE  = 1;
   localparam int POS_CLKSEL = 2;
   localparam int POS_REG    = 6;
   localparam int POS_PHY    = 11;
   localparam int BIT_RMII   = 23;
   localparam logic [15:0] RST_DATA = 16'h0000;
   // -----------------------------------------------------------
   // Timing
   // -----------------------------------------------------------
   localparam int CLK_PERIOD_PS  = 5000;
   localparam int MDC_MIN_PER_NS = 400;
   localparam int MDC_MIN_HALF_CYC =
      (MDC_MIN_PER_NS * 1000 + 2 * CLK_PERIOD_PS - 1)
      / (2 * CLK_PERIOD_PS);
   localparam int DIV_SEL0 = 42;
   localparam int DIV_SEL1 = 64;
   localparam int DIV_SEL2 = 26;
   localparam int DIV_SEL3 = 16;
   localparam int FRAME_BITS = 64;
   localparam int RD_TA_BIT  = 46;
   localparam int DATA_BIT   = 48;
   localparam logic [3:0] RX_FALSE_CARRIER = 4'hE;
   // -----------------------------------------------------------
   // Types
   // -----------------------------------------------------------
   typedef struct packed {
      logic [4:0] phyAddr;
      logic [4:0] regAddr;
      logic [2:0] clkSel;
      logic       wrSel;
      logic       busy;
   } ephy_ctrl_t;
   typedef enum logic [0:0] {SMI_IDLE, SMI_RUN} ephy_smi_t;
endpackage

// ===== rtl/ephy_port.sv
/*
 PHY-side port of an Ethernet MAC: AHB-Lite register slave, station
 management master, MII/RMII nibble transmit and receive paths.
 Assumes PHY clocks and pins are sampled on core_clk (200 MHz).
*/
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
// What this block does
// - Five-bit PHY address reaches 32 PHYs, one register per transaction.
// - Management clock half period floored so it never exceeds 2.5 MHz.
// - Management clock output stays low while idle.
// - Busy set with write select 1 sends data register to PHY.
// - Busy set with write select 0 reads the chosen PHY register.
// - Setting busy starts; busy reads high until hardware clears it.
// - Address and data writes ignored while busy; no error given.
// - Divider codes 0..3 name 42, 64, 26, 16; each is raised to the minimum, so all divide core clock by 80.
// - Transmit enable rises with first nibble, stays for every nibble.
// - Four bits per clock, bit 0 least significant; idle data ignored.
// - Carrier sense and collision are synchronised before use.
// - Receive nibbles are sampled only while receive valid is high.
// - Receive error decoded with receive valid and nibble value.
// - PHY clocks are foreign; synchronised and edge detected here.
// - Reduced mode shares a 50 MHz reference, two bits per clock.
// - Reduced mode sends low dibit first, then high dibit.
module ephy_port
   import ephy_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   output logic             mdc,
   input  wire logic        mdioIn,
   output logic             mdioOut,
   output logic             mdioOeN,
   input  wire logic        txClk,
   input  wire logic        rxClk,
   input  wire logic        refClk,
   output logic [3:0]       txd,
   output logic             txEn,
   input  wire logic [3:0]  rxd,
   input  wire logic        rxDv,
   input  wire logic        rxEr,
   input  wire logic        crs,
   input  wire logic        col,
   input  wire logic        txValid,
   input  wire logic [3:0]  txNibble,
   output logic             txReady,
   output logic [3:0]       rxNibble,
   output logic             rxValid,
   output logic             rxDataErr,
   output logic             rxFalseCarrier,
   output logic             rmiiMode
);
   // ----------------------------------------------------------
   // Functions
   // ----------------------------------------------------------
   // Half period of the management clock in core cycles
   function automatic logic [6:0] halfCycles(input logic [2:0] sel);
      int d;
      case (sel)
         3'h0:    d = DIV_SEL0;
         3'h1:    d = DIV_SEL1;
         3'h2:    d = DIV_SEL2;
         3'h3:    d = DIV_SEL3;
         default: d = DIV_SEL1;
      endcase
      d = d / 2;
      if (d < MDC_MIN_HALF_CYC) begin
         d = MDC_MIN_HALF_CYC;
      end
      return 7'(d);
   endfunction

   // Builds the 64-bit management frame, first bit in bit 63
   function automatic logic [63:0] smiFrame(input ephy_ctrl_t c,
                                            input logic [15:0] dat);
      logic [1:0] op;
      logic [1:0] ta;
      op = c.wrSel ? 2'b01 : 2'b10;
      ta = c.wrSel ? 2'b10 : 2'b11;
      return {32'hFFFF_FFFF, 2'b01, op, c.phyAddr, c.regAddr, ta,
              c.wrSel ? dat : 16'hFFFF};
   endfunction

   // Rising-edge detector on delayed synchronised levels
   function automatic logic rose(input logic now, input logic old);
      return now & ~old;
   endfunction

   // ----------------------------------------------------------
   // Register state
   // ----------------------------------------------------------
   ephy_ctrl_t  ctrl_q;
   logic [15:0] data_q;
   logic        rmii_q;
   logic [31:0] rdata_q;
   logic        wrPend_q;
   logic [7:0]  wrOfs_q;
   logic        accept;
   logic        wrFire;
   logic [1:0]  crsS_q;
   logic [1:0]  colS_q;
   logic        rxDvSeen_q;

   assign accept    = hsel & hready & htrans[1];
   assign wrFire    = wrPend_q & clkEn;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;
   assign rmiiMode  = rmii_q;

   // ----------------------------------------------------------
   // Management engine state
   // ----------------------------------------------------------
   ephy_smi_t   smi_q;
   logic [63:0] shift_q;
   logic [5:0]  bitCnt_q;
   logic [6:0]  halfCnt_q;
   logic        mdc_q;
   logic        mdioOut_q;
   logic        mdioOeN_q;
   logic        smiDone;
   logic        halfEnd;

   assign halfEnd = (halfCnt_q == 7'd1);
   assign smiDone = (smi_q == SMI_RUN) & halfEnd & mdc_q &
                    (bitCnt_q == 6'(FRAME_BITS - 1));

   // AHB address phase capture and read data
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPend_q <= 1'b0;
         wrOfs_q  <= 8'h00;
         rdata_q  <= 32'h0000_0000;
      end else if (clkEn) begin
         wrPend_q <= accept & hwrite;
         wrOfs_q  <= haddr[7:0];
         if (accept && !hwrite && haddr[31:8] == 24'h00_0000) begin
            case (haddr[7:0])
               OFS_ADDR_CTRL: rdata_q <= {16'h0000, ctrl_q.phyAddr,
                  ctrl_q.regAddr, 1'b0, ctrl_q.clkSel, ctrl_q.wrSel,
                  ctrl_q.busy};
               OFS_DATA:   rdata_q <= {16'h0000, data_q};
               OFS_CFG:    rdata_q <= 32'(rmii_q) << BIT_RMII;
               OFS_STATUS: rdata_q <= {29'h0000_0000, crsS_q[1],
                                       colS_q[1], rxDvSeen_q};
               default:    rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Control register: busy cleared by engine, writes held off
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= '0;
      end else if (clkEn) begin
         if (smiDone) begin
            ctrl_q.busy <= 1'b0;
         end else if (wrFire && wrOfs_q == OFS_ADDR_CTRL &&
                      !ctrl_q.busy) begin
            ctrl_q.busy    <= hwdata[BIT_BUSY];
            ctrl_q.wrSel   <= hwdata[BIT_WRITE];
            ctrl_q.clkSel  <= hwdata[POS_CLKSEL +: 3];
            ctrl_q.regAddr <= hwdata[POS_REG +: 5];
            ctrl_q.phyAddr <= hwdata[POS_PHY +: 5];
         end
      end
   end

   // Data register: software write or read capture at completion
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_q <= RST_DATA;
      end else if (clkEn) begin
         if (smiDone && !ctrl_q.wrSel) begin
            data_q <= shift_q[15:0];
         end else if (wrFire && wrOfs_q == OFS_DATA && !ctrl_q.busy) begin
            data_q <= hwdata[15:0];
         end
      end
   end

   // Interface select; meant to be set only while held in reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rmii_q <= 1'b0;
      end else if (clkEn && wrFire && wrOfs_q == OFS_CFG) begin
         rmii_q <= hwdata[BIT_RMII];
      end
   end

   // ----------------------------------------------------------
   // Station management engine
   // ----------------------------------------------------------
   // Bit sequencer: drive on low half, sample at rising edge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         smi_q     <= SMI_IDLE;
         shift_q   <= 64'h0000_0000_0000_0000;
         bitCnt_q  <= 6'd0;
         halfCnt_q <= 7'd0;
         mdc_q     <= 1'b0;
      end else if (clkEn) begin
         case (smi_q)
            SMI_IDLE: begin
               mdc_q <= 1'b0;
               if (ctrl_q.busy) begin
                  smi_q     <= SMI_RUN;
                  shift_q   <= smiFrame(ctrl_q, data_q);
                  bitCnt_q  <= 6'd0;
                  halfCnt_q <= halfCycles(ctrl_q.clkSel);
               end
            end
            SMI_RUN: begin
               if (!halfEnd) begin
                  halfCnt_q <= halfCnt_q - 7'd1;
               end else begin
                  halfCnt_q <= halfCycles(ctrl_q.clkSel);
                  mdc_q     <= ~mdc_q;
                  if (!mdc_q) begin
                     // Rising edge: sample reply bit into the tail
                     shift_q <= {shift_q[62:0], mdioIn};
                  end else if (smiDone) begin
                     smi_q <= SMI_IDLE;
                     mdc_q <= 1'b0;
                  end else begin
                     bitCnt_q <= bitCnt_q + 6'd1;
                  end
               end
            end
            default: smi_q <= SMI_IDLE;
         endcase
      end
   end

   // Pin drive: frame bit presented during the low half
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mdioOut_q <= 1'b1;
         mdioOeN_q <= 1'b1;
      end else if (clkEn) begin
         if (smi_q == SMI_RUN && !mdc_q) begin
            mdioOut_q <= shift_q[63];
            mdioOeN_q <= !ctrl_q.wrSel &&
                         bitCnt_q >= 6'(RD_TA_BIT);
         end else if (smi_q == SMI_IDLE) begin
            mdioOeN_q <= 1'b1;
         end
      end
   end

   assign mdc     = mdc_q;
   assign mdioOut = mdioOut_q;
   assign mdioOeN = mdioOeN_q;

   // ----------------------------------------------------------
   // PHY clock and status synchronisers
   // ----------------------------------------------------------
   logic [2:0] txClkS_q;
   logic [2:0] rxClkS_q;
   logic [2:0] refClkS_q;
   logic [3:0] rxdS1_q;
   logic [3:0] rxdS2_q;
   logic [1:0] rxDvS_q;
   logic [1:0] rxErS_q;
   logic       txEdge;
   logic       rxEdge;

   // Two flops per level, third flop only for edge detection
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         txClkS_q  <= 3'b000;
         rxClkS_q  <= 3'b000;
         refClkS_q <= 3'b000;
         crsS_q    <= 2'b00;
         colS_q    <= 2'b00;
         rxdS1_q   <= 4'h0;
         rxdS2_q   <= 4'h0;
         rxDvS_q   <= 2'b00;
         rxErS_q   <= 2'b00;
      end else if (clkEn) begin
         txClkS_q  <= {txClkS_q[1:0], txClk};
         rxClkS_q  <= {rxClkS_q[1:0], rxClk};
         refClkS_q <= {refClkS_q[1:0], refClk};
         crsS_q    <= {crsS_q[0], crs};
         colS_q    <= {colS_q[0], col};
         rxdS1_q   <= rxd;
         rxdS2_q   <= rxdS1_q;
         rxDvS_q   <= {rxDvS_q[0], rxDv};
         rxErS_q   <= {rxErS_q[0], rxEr};
      end
   end

   // MII transmit changes after falling edge, reduced mode after rising edge; receive samples rising edge
   assign txEdge = rmii_q ? rose(refClkS_q[1], refClkS_q[2])
                          : rose(txClkS_q[2], txClkS_q[1]);
   assign rxEdge = rmii_q ? rose(refClkS_q[1], refClkS_q[2])
                          : rose(rxClkS_q[1], rxClkS_q[2]);

   // ----------------------------------------------------------
   // Transmit path
   // ----------------------------------------------------------
   logic [3:0] txd_q;
   logic       txEn_q;
   logic       txHigh_q;
   logic [1:0] txHold_q;

   // Nibble is taken when the link edge is due and no dibit pends
   assign txReady = txEdge & ~txHigh_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         txd_q    <= 4'h0;
         txEn_q   <= 1'b0;
         txHigh_q <= 1'b0;
         txHold_q <= 2'b00;
      end else if (clkEn && txEdge) begin
         if (txHigh_q) begin
            txd_q    <= {2'b00, txHold_q};
            txHigh_q <= 1'b0;
         end else if (txValid) begin
            txEn_q <= 1'b1;
            if (rmii_q) begin
               txd_q    <= {2'b00, txNibble[1:0]};
               txHold_q <= txNibble[3:2];
               txHigh_q <= 1'b1;
            end else begin
               txd_q <= txNibble;
            end
         end else begin
            txEn_q <= 1'b0;
            txd_q  <= 4'h0;
         end
      end
   end

   assign txd  = txd_q;
   assign txEn = txEn_q;

   // ----------------------------------------------------------
   // Receive path
   // ----------------------------------------------------------
   logic [3:0] rxNib_q;
   logic       rxVal_q;
   logic       rxDErr_q;
   logic       rxFc_q;
   logic       rxHigh_q;
   logic [1:0] rxLow_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxNib_q  <= 4'h0;
         rxVal_q  <= 1'b0;
         rxDErr_q <= 1'b0;
         rxFc_q   <= 1'b0;
         rxHigh_q <= 1'b0;
         rxLow_q  <= 2'b00;
      end else if (clkEn) begin
         rxVal_q  <= 1'b0;
         rxDErr_q <= 1'b0;
         rxFc_q   <= 1'b0;
         if (rxEdge) begin
            // Error cause from error, valid and nibble together
            rxDErr_q <= rxErS_q[1] & rxDvS_q[1];
            rxFc_q   <= rxErS_q[1] & ~rxDvS_q[1] &
                        (rxdS2_q == RX_FALSE_CARRIER);
            if (!rxDvS_q[1]) begin
               rxHigh_q <= 1'b0;
            end else if (!rmii_q) begin
               rxNib_q <= rxdS2_q;
               rxVal_q <= 1'b1;
            end else if (!rxHigh_q) begin
               rxLow_q  <= rxdS2_q[1:0];
               rxHigh_q <= 1'b1;
            end else begin
               rxNib_q  <= {rxdS2_q[1:0], rxLow_q};
               rxVal_q  <= 1'b1;
               rxHigh_q <= 1'b0;
            end
         end
      end
   end

   // Receive-valid activity flag for the status register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxDvSeen_q <= 1'b0;
      end else if (clkEn) begin
         rxDvSeen_q <= rxDvS_q[1];
      end
   end

   assign rxNibble       = rxNib_q;
   assign rxValid        = rxVal_q;
   assign rxDataErr      = rxDErr_q;
   assign rxFalseCarrier = rxFc_q;
endmodule

// ===== tb/ephy_port_sva.sv
/*
 Checker for ephy_port, watching top-level ports only.
 Assumes one core clock domain and an active-low reset.
*/
module ephy_port_sva
   import ephy_pkg::*;
(
   input logic       core_clk,
   input logic       rst_n,
   input logic       hreadyout,
   input logic       hresp,
   input logic       mdc,
   input logic       mdioOut,
   input logic       mdioOeN,
   input logic [3:0] txd,
   input logic       txEn,
   input logic       txValid,
   input logic [3:0] txNibble,
   input logic       txReady,
   input logic       rxDv,
   input logic       rxValid,
   input logic       rmiiMode
);
   logic        mdcQ;
   logic [15:0] cnt;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // Cycles since the management clock last changed level
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mdcQ <= 1'b0;
         cnt  <= 16'h0000;
      end else begin
         mdcQ <= mdc;
         if (mdc != mdcQ) begin
            cnt <= 16'h0001;
         end else if (cnt != 16'hFFFF) begin
            cnt <= cnt + 16'h0001;
         end
      end
   end

   chk_mdc_high_max: assert property (
      mdc && mdcQ |-> cnt < 16'd40) else $error("mdc high too long");
   chk_mdc_half_time: assert property (
      $fell(mdc) |-> cnt == 16'd40) else $error("mdc high time wrong");
   chk_bus_okay: assert property (
      hreadyout && !hresp) else $error("bus not ready or not okay");
   chk_tx_en_follow: assert property (
      txReady && txValid |=> txEn) else $error("txEn missing");
   chk_tx_end: assert property (
      txReady && !txValid |=> !txEn) else $error("txEn not dropped");
   chk_mii_nibble: assert property (
      txReady && txValid && !rmiiMode |=> txd == $past(txNibble))
      else $error("mii nibble wrong");
   chk_rmii_dibit: assert property (
      txReady && txValid && rmiiMode |=> txd == ($past(txNibble) & 4'h3))
      else $error("rmii low dibit wrong");
   chk_rx_gate: assert property (
      !rxDv [*8] |-> !rxValid) else $error("rx nibble without valid");
   chk_mdio_edge: assert property (
      $changed(mdioOut) || $changed(mdioOeN) |-> !mdc)
      else $error("mdio moved while mdc high");

   cover property ($fell(mdc));
   cover property (txReady && txValid && rmiiMode);
   cover property (rxValid);
endmodule

bind ephy_port ephy_port_sva u_sva (.core_clk, .rst_n, .hreadyout, .hresp,
   .mdc, .mdioOut, .mdioOeN, .txd, .txEn, .txValid, .txNibble, .txReady,
   .rxDv, .rxValid, .rmiiMode);

// ===== tb/ephy_phy_model.sv
/*
 Behavioural external PHY: management responder, MII/RMII clocks,
 receive frames, transmit capture. Assumes an mdio pull-up.
*/
module ephy_phy_model (
   input  wire logic       mdc,
   input  wire logic       mdioOut,
   input  wire logic       mdioOeN,
   input  wire logic       clkOn,
   input  wire logic       refOn,
   input  wire logic [3:0] txd,
   input  wire logic       txEn,
   output logic            mdioIn,
   output logic            txClk,
   output logic            rxClk,
   output logic            refClk,
   output logic [3:0]      rxd,
   output logic            rxDv,
   output logic            rxEr,
   output logic            crs,
   output logic            col
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] rdWord;
   logic [31:0] wrSh;
   logic [3:0]  txSeen[$];
   logic        phyEn;
   logic        phyBit;
   int          k;

   // Wire level: device, else PHY, else pull-up
   assign mdioIn = !mdioOeN ? mdioOut : (phyEn ? phyBit : 1'b1);
   initial begin
      {txClk, rxClk, refClk, rxDv, rxEr, crs, col, phyEn} = '0;
      {rxd, phyBit, k, wrSh, rdWord} = '0;
   end
   // Capture driven bits, count bits after release
   always @(posedge mdc) begin
      if (!mdioOeN) begin
         wrSh <= {wrSh[30:0], mdioOut};
         k    <= 0;
      end else begin
         k    <= k + 1;
      end
   end
   // Turnaround zero, then read data MSB first
   always @(posedge mdc) begin
      #10;
      phyEn  = mdioOeN && k >= 1 && k <= 17;
      phyBit = (k == 1) ? 1'b0 : rdWord[17-k];
   end
   // 10 Mbit/s transmit clock and shared reference, only when enabled
   always #200 txClk = clkOn ? ~txClk : 1'b0;
   always #10 refClk = refOn ? ~refClk : 1'b0;
   // Transmit nibbles only count while enable is high
   always @(posedge txClk) if (txEn) txSeen.push_back(txd);

   // Receive frame, nibbles low first; error flag held as asked
   task automatic rx_frame(input logic [15:0] nib, input int cnt,
                           input logic dv, input logic er);
      for (int i = 0; i < cnt; i++) begin
         rxd  = nib[4*i +: 4];
         rxDv = dv;
         rxEr = er;
         #200 rxClk = 1'b1;
         #200 rxClk = 1'b0;
      end
      rxDv = 1'b0;
      rxEr = 1'b0;
      rxd  = ~rxd;
   endtask
endmodule

// ===== tb/ephy_port_tb.sv
/*
 Self-checking bench for ephy_port with the PHY model.
 Assumes zero-wait AHB-Lite slave and 200 MHz core clock.
*/
module ephy_port_tb;
   import ephy_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 0, rst_n = 0, clkEn = 1, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'b010;
   logic hready, hreadyout, hresp, mdc, mdioIn, mdioOut, mdioOeN;
   logic txClk, rxClk, refClk, txEn, rxDv, rxEr, crs, col, txReady;
   logic rxValid, rxDataErr, rxFalseCarrier, rmiiMode;
   logic txValid = 0, clkOn = 0, refOn = 0;
   logic [3:0] txd, rxd, rxNibble, txNibble = 0;
   int err_total = 0, checked = 0;

   assign hready = hreadyout;
   initial forever #2.5 core_clk = ~core_clk;
   ephy_port uut (.core_clk, .rst_n, .clkEn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .mdc,
      .mdioIn, .mdioOut, .mdioOeN, .txClk, .rxClk, .refClk, .txd, .txEn,
      .rxd, .rxDv, .rxEr, .crs, .col, .txValid, .txNibble, .txReady,
      .rxNibble, .rxValid, .rxDataErr, .rxFalseCarrier, .rmiiMode);
   ephy_phy_model phy (.mdc, .mdioOut, .mdioOeN, .clkOn, .refOn, .txd,
      .txEn, .mdioIn, .txClk, .rxClk, .refClk, .rxd, .rxDv, .rxEr, .crs,
      .col);

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Wait for ready at a rising edge, bounded
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin @(posedge core_clk); n++; end
      while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin err_total++; wrap_up(); end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 0; htrans <= 2'b00; hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask
   // Poll busy until clear, bounded
   task automatic smi_wait;
      logic [31:0] q;
      int n;
      ahb(0, OFS_ADDR_CTRL, 0, q);
      chk("busy", 1, q[0]);
      n = 0;
      do begin repeat (8) @(posedge core_clk); ahb(0, OFS_ADDR_CTRL, 0, q); n++;
      end while (q[0] !== 1'b0 && n < 1000);
      if (n >= 1000) begin err_total++; wrap_up(); end
   endtask

   // Write frame; writes during busy are ignored
   task automatic t_smi_write;
      logic [31:0] q;
      ahb(1, OFS_DATA, 32'h0000_A5C3, q);
      ahb(1, OFS_ADDR_CTRL, 32'h0000_F80F, q);
      ahb(1, OFS_DATA, 32'h0000_FFFF, q);
      ahb(1, OFS_ADDR_CTRL, 32'h0000_0001, q);
      smi_wait();
      chk("frame", {4'b0101, 5'h1F, 5'h00, 2'b10, 16'hA5C3}, phy.wrSh);
      ahb(0, OFS_DATA, 0, q);
      chk("data", 32'h0000_A5C3, q);
      ahb(0, OFS_ADDR_CTRL, 0, q);
      chk("ctrl", 32'h0000_F80E, q);
   endtask
   // Reads with divider codes 0..3
   task automatic t_smi_read;
      logic [31:0] q;
      logic [4:0]  p, r;
      for (int c = 0; c < 4; c++) begin
         p = 5'(c * 10 + 1);
         r = 5'(31 - c);
         phy.rdWord = 16'h3C96 + 16'(c);
         ahb(1, OFS_ADDR_CTRL, {16'h0, p, r, 1'b0, 3'(c), 2'b01}, q);
         smi_wait();
         chk("header", {4'b0110, p, r}, phy.wrSh[13:0]);
         ahb(0, OFS_DATA, 0, q);
         chk("rdata", 16'h3C96 + 16'(c), q);
      end
   endtask
   // MII transmit of four nibbles
   task automatic t_mii_tx;
      logic [3:0] nb[4] = '{4'h5, 4'h5, 4'hD, 4'hA};
      int n;
      clkOn <= 1; txNibble <= nb[0]; txValid <= 1;
      for (int i = 0; i < 4; i++) begin
         n = 0;
         do begin @(negedge core_clk); n++; end
         while (txReady !== 1'b1 && n < 1000);
         if (txReady !== 1'b1) begin err_total++; wrap_up(); end
         @(posedge core_clk);
         if (i < 3) txNibble <= nb[i+1]; else txValid <= 0;
      end
      repeat (400) @(posedge core_clk);
      chk("txcount", 4, phy.txSeen.size());
      foreach (phy.txSeen[i]) chk("txd", nb[i], phy.txSeen[i]);
      clkOn <= 0;
   endtask
   // Receive one frame or a false carrier
   task automatic t_rx(input logic dv, er, input int nv, nf, ne);
      int v, f, e;
      v = 0; f = 0; e = 0;
      // Link pins move off the core clock's sampling edge
      @(negedge core_clk);
      fork
         phy.rx_frame(16'hD5AE, dv ? 4 : 1, dv, er);
         repeat (500) begin
            @(negedge core_clk);
            if (rxValid === 1'b1) begin
               chk("rxNibble", (16'hD5AE >> (4*v)) & 16'h000F,
                   rxNibble);
               v++;
            end
            if (rxFalseCarrier === 1'b1) f++;
            if (rxDataErr === 1'b1) e++;
         end
      join
      chk("rxcount", nv, v);
      chk("falsecarrier", nf, f);
      chk("dataerr", ne, e);
   endtask
   // Status sync, then reduced mode dibits
   task automatic t_rmii;
      logic [31:0] q;
      int n;
      phy.crs = 1; phy.col = 1;
      repeat (10) @(posedge core_clk);
      ahb(0, OFS_STATUS, 0, q);
      chk("status", 32'h0000_0006, q);
      phy.crs <= 0; phy.col <= 0;
      ahb(1, OFS_CFG, 32'h0080_0000, q);
      @(negedge core_clk);
      chk("rmiiMode", 1, rmiiMode);
      @(posedge core_clk);
      refOn <= 1; txNibble <= 4'hB; txValid <= 1;
      n = 0;
      do begin @(negedge core_clk); n++; end
      while (txReady !== 1'b1 && n < 100);
      if (txReady !== 1'b1) begin err_total++; wrap_up(); end
      @(posedge core_clk);
      txValid <= 0;
      @(negedge core_clk);
      chk("dibit low", 4'h3, txd);
      repeat (4) @(negedge core_clk);
      chk("dibit high", 4'h2, txd);
      repeat (4) @(negedge core_clk);
      chk("txEn end", 0, txEn);
      refOn <= 0;
   endtask

   initial begin
      logic [31:0] q;
      repeat (12) @(posedge core_clk);
      rst_n <= 1;
      @(negedge core_clk);
      chk("mdc", 0, mdc);
      chk("rmiiMode", 0, rmiiMode);
      @(posedge core_clk);
      ahb(0, 8'h10, 0, q);
      chk("unmapped", 0, q);
      t_smi_write();
      t_smi_read();
      t_mii_tx();
      t_rx(1, 0, 4, 0, 0);
      t_rx(0, 1, 0, 1, 0);
      t_rx(1, 1, 4, 0, 4);
      t_rmii();
      wrap_up();
   end
endmodule
